// [rtl/pcr_phy_ctrl.sv]
// Purpose: Transceiver configuration register with read-back, APB reachable
// Assumes: Mode and link event inputs are synchronous to pclk
// Notes: Command word written at ADDR_CMD; reply readable at the same offset
//
// Notes on behaviour
// - Command word with top address bits 11 addresses this control register.
// - Read-select bit 13 picks general purpose read-back 1, else the feedback.
// - Bit 12 set returns the reply only; clear also writes the control register.
// - Bit 11 keeps the CAN supply regulator on during off-line mode.
// - Bit 10 selects listen instead of on-line; cleared on entering on-line or active.
// - Bit 9 picks long or short off-line timeout; extended after a wake-up.
// - Off-line is entered only after bus idle for the selected timeout.
// - Bit 8 set disables the CAN transmitter.
// - Bits 7 and 8 both set loop CAN transmit data to receive output.
// - Bit 6 gives CAN active mode only in normal or flash mode.
// - Bit 5 drives the split output, otherwise it floats.
// - Bit 4 gives LIN active mode only in normal or flash mode.
// - Bit 3 selects low LIN slope, else normal slope.
// - Bit 2 selects increased LIN driver current.
// - Bit 1 lets LIN bus wake-up events through.
// - Bit 0 set disables the LIN transmitter.
// - CAN interface failure locks the transmitter off; good traffic releases it.
// - Writing bit 8 set then cleared releases the CAN lockout.
// - LIN interface failure locks the transmitter off; good traffic releases it.
// - Writing bit 0 set then cleared releases the LIN lockout.
// - Feedback register reports the applied control settings.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module pcr_phy_ctrl
   import pcr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_normal_or_flash,
   input wire logic wake_event,
   input wire logic can_bus_activity,
   input wire logic can_bus_rx,
   input wire logic can_transmit_pin,
   input wire logic can_if_fail,
   input wire logic can_if_good_traffic,
   input wire logic lin_if_fail,
   input wire logic lin_if_good_traffic,
   input wire logic lin_bus_wake,
   output logic can_supply_regulator,
   output logic can_online_listen,
   output logic can_offline,
   output logic can_active,
   output logic can_tx_enable,
   output logic can_receive_pin,
   output logic split_output_enable,
   output logic lin_active,
   output logic lin_low_slope,
   output logic lin_strong_drive,
   output logic lin_wake_event,
   output logic lin_tx_enable
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (OFF_EXT_CYC >= (1 << CNT_W) || OFF_SHORT_CYC < 1)
   begin : g_bad_timeout
      $error("Off-line timeout does not fit the idle counter");
   end

   // ************************************************************
   // Decode helpers
   // ************************************************************
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_CMD) || (a == ADDR_GP1) || (a == ADDR_STATUS);
   endfunction

   logic [11:0] ctrl;
   logic [11:0] gp1;
   logic [15:0] reply;
   logic [1:0] lock;
   logic after_wake;
   logic [11:0] idle_cnt;
   pcr_can_state_e state;
   pcr_can_state_e next_state;

   logic wr_done;
   logic cmd_wr;
   logic cmd_hit;
   logic ctrl_wr;
   logic [15:0] cmd_word;
   logic [15:0] feedback;
   logic active_ok;
   logic [11:0] timeout;
   logic enter_on;
   logic [1:0] if_fail;
   logic [1:0] if_good;
   logic [1:0] manual_clr;

   assign wr_done = psel && penable && pready && pwrite;
   assign cmd_word = pwdata[15:0];
   assign cmd_wr = wr_done && (paddr == ADDR_CMD);
   assign cmd_hit = (cmd_word[B_SEL_HI:B_SEL_LO] == SEL_PHY);
   assign ctrl_wr = cmd_wr && cmd_hit && !cmd_word[B_NO_WRITE];
   assign feedback = {SEL_PHY, 2'b00, ctrl};
   assign active_ok = ctrl[B_CAN_ACT] && chip_normal_or_flash;

   // ************************************************************
   // APB slave, one wait state
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !is_mapped(paddr);
         if (pwrite || !is_mapped(paddr))
            prdata <= 32'h0000_0000;
         else if (paddr == ADDR_CMD)
            prdata <= {16'h0000, reply};
         else if (paddr == ADDR_GP1)
            prdata <= {20'h00000, gp1};
         else
            prdata <= {15'h0000, after_wake, state, lock, ctrl};
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gp1 <= GP1_RESET;
      else if (wr_done && paddr == ADDR_GP1)
         gp1 <= pwdata[11:0];
   end

   // ************************************************************
   // Command word handling
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reply <= 16'h0000;
      else if (cmd_wr)
      begin
         if (!cmd_hit)
            reply <= 16'h0000;
         else if (cmd_word[B_READBACK_SEL])
            reply <= {4'h0, gp1};
         else
            reply <= feedback;
      end
   end

   // Write wins over the self-clear of the listen bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= CTRL_RESET;
      else if (ctrl_wr)
         ctrl <= cmd_word[11:0];
      else if (enter_on)
         ctrl[B_PN_LISTEN] <= 1'b0;
   end

   // ************************************************************
   // Interface failure lockouts, index 1 CAN, index 0 LIN
   // ************************************************************
   assign if_fail = {can_if_fail, lin_if_fail};
   assign if_good = {can_if_good_traffic, lin_if_good_traffic};
   assign manual_clr[1] = ctrl_wr && ctrl[B_CAN_TX_OFF] && !cmd_word[B_CAN_TX_OFF];
   assign manual_clr[0] = ctrl_wr && ctrl[B_LIN_TX_OFF] && !cmd_word[B_LIN_TX_OFF];

   for (genvar i = 0; i < 2; i++)
   begin : g_lock
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            lock[i] <= 1'b0;
         else if (if_fail[i])
            lock[i] <= 1'b1;
         else if (if_good[i] || manual_clr[i])
            lock[i] <= 1'b0;
      end
   end

   // ************************************************************
   // CAN transceiver mode and off-line timeout
   // ************************************************************
   always_comb
   begin
      if (after_wake)
         timeout = 12'(OFF_EXT_CYC);
      else if (ctrl[B_OFF_TIME])
         timeout = 12'(OFF_LONG_CYC);
      else
         timeout = 12'(OFF_SHORT_CYC);
   end

   always_comb
   begin
      next_state = state;
      case (state)
         PCR_OFFLINE:
         begin
            if (active_ok)
               next_state = PCR_ACTIVE;
            else if (can_bus_activity)
               next_state = ctrl[B_PN_LISTEN] ? PCR_LISTEN : PCR_ONLINE;
         end
         PCR_ONLINE, PCR_LISTEN:
         begin
            if (active_ok)
               next_state = PCR_ACTIVE;
            else if (!can_bus_activity && idle_cnt >= timeout)
               next_state = PCR_OFFLINE;
         end
         PCR_ACTIVE:
         begin
            if (!active_ok)
               next_state = ctrl[B_PN_LISTEN] ? PCR_LISTEN : PCR_ONLINE;
         end
         default: next_state = PCR_OFFLINE;
      endcase
   end

   assign enter_on = (next_state != state) &&
                     (next_state == PCR_ONLINE || next_state == PCR_ACTIVE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= PCR_OFFLINE;
      else
         state <= next_state;
   end

   // Counts consecutive idle cycles while on-line or listening
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idle_cnt <= 12'h000;
      else if (can_bus_activity || next_state == PCR_OFFLINE || next_state == PCR_ACTIVE)
         idle_cnt <= 12'h000;
      else if (idle_cnt != 12'hfff)
         idle_cnt <= idle_cnt + 12'h001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         after_wake <= 1'b0;
      else if (wake_event)
         after_wake <= 1'b1;
      else if (state != PCR_OFFLINE && next_state == PCR_OFFLINE)
         after_wake <= 1'b0;
   end

   // ************************************************************
   // Transceiver control outputs
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         can_supply_regulator <= 1'b0;
         can_online_listen <= 1'b0;
         can_offline <= 1'b1;
         can_active <= 1'b0;
         can_tx_enable <= 1'b0;
         can_receive_pin <= 1'b1;
         split_output_enable <= 1'b0;
      end
      else
      begin
         can_supply_regulator <= (state != PCR_OFFLINE) || ctrl[B_SUPPLY_KEEP];
         can_online_listen <= (state == PCR_LISTEN);
         can_offline <= (state == PCR_OFFLINE);
         can_active <= (state == PCR_ACTIVE);
         can_tx_enable <= !ctrl[B_CAN_TX_OFF] && !lock[1];
         if (ctrl[B_CAN_TX_OFF] && ctrl[B_CAN_LOOP])
            can_receive_pin <= can_transmit_pin;
         else
            can_receive_pin <= can_bus_rx;
         split_output_enable <= ctrl[B_SPLIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lin_active <= 1'b0;
         lin_low_slope <= 1'b0;
         lin_strong_drive <= 1'b0;
         lin_wake_event <= 1'b0;
         lin_tx_enable <= 1'b0;
      end
      else
      begin
         lin_active <= ctrl[B_LIN_ACT] && chip_normal_or_flash;
         lin_low_slope <= ctrl[B_LIN_SLOPE];
         lin_strong_drive <= ctrl[B_LIN_DRIVE];
         lin_wake_event <= lin_bus_wake && ctrl[B_LIN_WAKE];
         lin_tx_enable <= !ctrl[B_LIN_TX_OFF] && !lock[0];
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   // Listen bit may self-clear in the same cycle
   cmd_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && !cmd_hit) |=>
         (ctrl == $past(ctrl & ~(12'(enter_on) << B_PN_LISTEN))) && (reply == 16'h0000))
      else $error("Foreign address changed control register");

   reply_gp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_hit && cmd_word[B_READBACK_SEL]) |=> (reply == {4'h0, $past(gp1)}))
      else $error("Reply does not carry general purpose read-back");

   read_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_hit && cmd_word[B_NO_WRITE]) |=>
         (ctrl == $past(ctrl & ~(12'(enter_on) << B_PN_LISTEN))))
      else $error("Read-only command altered control register");

   write_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> (ctrl == $past(cmd_word[11:0])) ##1 (lin_low_slope == ctrl[B_LIN_SLOPE]))
      else $error("Write command not applied");

   reply_fb_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_hit && !cmd_word[B_READBACK_SEL]) |=> (reply[11:0] == $past(ctrl)))
      else $error("Feedback does not show applied settings");

   can_tx_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (can_if_fail ##1 !can_if_good_traffic && !manual_clr[1]) |=> !can_tx_enable)
      else $error("CAN transmitter not locked after failure");

   lin_tx_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      lin_if_fail |=> ##1 !lin_tx_enable)
      else $error("LIN transmitter not locked after failure");

   lin_tx_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl[B_LIN_TX_OFF] |=> !lin_tx_enable)
      else $error("LIN transmitter not disabled by control bit");

   split_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      split_output_enable == $past(ctrl[B_SPLIT]))
      else $error("Split output does not follow control bit");

   lin_wake_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      lin_wake_event == $past(lin_bus_wake && ctrl[B_LIN_WAKE]))
      else $error("LIN wake event not gated by enable bit");

   loopback_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[B_CAN_TX_OFF] && ctrl[B_CAN_LOOP]) |=>
         (can_receive_pin == $past(can_transmit_pin)))
      else $error("Loopback path broken");

   busy_online_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == PCR_ONLINE && can_bus_activity) |=> (state != PCR_OFFLINE))
      else $error("Left on-line while bus busy");

   can_active_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(can_active) |-> $past(ctrl[B_CAN_ACT] && chip_normal_or_flash, 2))
      else $error("CAN active without request in allowed mode");

endmodule

// [rtl/pcr_pkg.sv]
// Purpose: Shared constants for the transceiver configuration register block
// Assumes: APB slave, 32-bit data, 20 MHz pclk
// Notes: Command word layout follows the 16-bit register command format
package pcr_pkg;

   // ************************************************************
   // APB register map
   // ************************************************************
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_GP1 = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // ************************************************************
   // Command word fields
   // ************************************************************
   localparam logic [1:0] SEL_PHY = 2'h3;
   localparam int B_SEL_HI = 15;
   localparam int B_SEL_LO = 14;
   localparam int B_READBACK_SEL = 13;
   localparam int B_NO_WRITE = 12;
   localparam int B_SUPPLY_KEEP = 11;
   localparam int B_PN_LISTEN = 10;
   localparam int B_OFF_TIME = 9;
   localparam int B_CAN_TX_OFF = 8;
   localparam int B_CAN_LOOP = 7;
   localparam int B_CAN_ACT = 6;
   localparam int B_SPLIT = 5;
   localparam int B_LIN_ACT = 4;
   localparam int B_LIN_SLOPE = 3;
   localparam int B_LIN_DRIVE = 2;
   localparam int B_LIN_WAKE = 1;
   localparam int B_LIN_TX_OFF = 0;
   localparam int CTRL_W = 12;
   localparam int GP_W = 12;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [11:0] CTRL_RESET = 12'h000;
   localparam logic [11:0] GP1_RESET = 12'h000;

   // ************************************************************
   // Off-line timeouts
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_OFFLINE_SHORT_US = 20;
   localparam int T_OFFLINE_LONG_US = 40;
   localparam int T_OFFLINE_EXT_US = 80;
   localparam int OFF_SHORT_CYC = (T_OFFLINE_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_LONG_CYC = (T_OFFLINE_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_EXT_CYC = (T_OFFLINE_EXT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   // ************************************************************
   // CAN transceiver states
   // ************************************************************
   typedef enum logic [1:0]
   {
      PCR_OFFLINE = 2'b00,
      PCR_ONLINE = 2'b01,
      PCR_LISTEN = 2'b10,
      PCR_ACTIVE = 2'b11
   } pcr_can_state_e;

endpackage

// [bench/pcr_host_model.sv]
// Purpose: Host side APB master issuing command words
// Assumes: One transfer at a time, called from the bench
// Notes: Address and data are inverted once released
module pcr_host_model
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // One whole word, held until pready is seen
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// [bench/test_phy_layer_control_regs.sv]
// Purpose: Self-checking bench for the transceiver configuration block
// Assumes: Host model drives APB; bench drives mode and link inputs
// Notes: Timeouts use the package cycle counts
module test_phy_layer_control_regs import pcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   logic chip_normal_or_flash = 1'b0, wake_event = 1'b0, can_bus_activity = 1'b0;
   logic can_bus_rx = 1'b0, can_transmit_pin = 1'b0, lin_bus_wake = 1'b0;
   logic [1:0] fail = 2'b00, good = 2'b00;
   logic can_supply_regulator, can_online_listen, can_offline, can_active;
   logic can_tx_enable, can_receive_pin, split_output_enable, lin_active;
   logic lin_low_slope, lin_strong_drive, lin_wake_event, lin_tx_enable;
   logic [1:0] txen;
   int bad_count = 0;
   int checks = 0;

   assign txen = {lin_tx_enable, can_tx_enable};
   always #25 pclk = ~pclk;

   pcr_host_model pcr_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   pcr_phy_ctrl pcr_phy_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_normal_or_flash(chip_normal_or_flash), .wake_event(wake_event),
      .can_bus_activity(can_bus_activity), .can_bus_rx(can_bus_rx),
      .can_transmit_pin(can_transmit_pin), .can_if_fail(fail[0]),
      .can_if_good_traffic(good[0]), .lin_if_fail(fail[1]),
      .lin_if_good_traffic(good[1]), .lin_bus_wake(lin_bus_wake),
      .can_supply_regulator(can_supply_regulator), .can_online_listen(can_online_listen),
      .can_offline(can_offline), .can_active(can_active), .can_tx_enable(can_tx_enable),
      .can_receive_pin(can_receive_pin), .split_output_enable(split_output_enable),
      .lin_active(lin_active), .lin_low_slope(lin_low_slope),
      .lin_strong_drive(lin_strong_drive), .lin_wake_event(lin_wake_event),
      .lin_tx_enable(lin_tx_enable));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d of %0d checks", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      pcr_host_model_i.xfer(1'b1, a, d, rd, er);
   endtask

   task automatic rdr(input logic [7:0] a);
      pcr_host_model_i.xfer(1'b0, a, 32'h00000000, rd, er);
   endtask

   // Command then fetch of its reply
   task automatic cmd(input logic [15:0] w);
      wr(ADDR_CMD, {16'h0000, w});
      rdr(ADDR_CMD);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      check({can_offline, can_tx_enable, lin_tx_enable, can_active, can_supply_regulator,
         split_output_enable, lin_active}, 7'h70);
      rdr(ADDR_STATUS);
      check(rd[11:0], 12'h000);
   endtask

   task automatic t_fields;
      logic [11:0] b, prev;
      prev = 12'h000;
      for (int i = 0; i < 12; i++)
      begin
         b = 12'h001 << i;
         // Mode off around bit 6 so the CAN state stays off-line
         @(posedge pclk);
         chip_normal_or_flash <= (i < 6 || i > 7);
         cmd({4'hc, b});
         check(rd, {16'h0000, 4'hc, prev});
         check({can_supply_regulator, split_output_enable, lin_low_slope, lin_strong_drive,
            can_tx_enable, lin_tx_enable, lin_active},
            {b[11], b[5], b[3], b[2], ~b[8], ~b[0], b[4]});
         rdr(ADDR_STATUS);
         check(rd[11:0], b);
         prev = b;
      end
      cmd(16'hc000);
   endtask

   task automatic t_select;
      wr(ADDR_GP1, 32'h000005a3);
      rdr(ADDR_GP1);
      check(rd, 32'h000005a3);
      cmd(16'hc123);
      cmd(16'hffff);
      check(rd, 32'h000005a3);
      rdr(ADDR_STATUS);
      check(rd[11:0], 12'h123);
      cmd(16'h3fff);
      check(rd, 32'h00000000);
      rdr(ADDR_STATUS);
      check(rd[11:0], 12'h123);
      cmd(16'hc000);
      check(rd, 32'h0000c123);
      rdr(8'h0c);
      check({er, rd}, 33'h100000000);
   endtask

   task automatic t_loop;
      cmd(16'hc180);
      @(posedge pclk);
      can_bus_rx <= 1'b1;
      tick(3);
      check(can_receive_pin, 1'b0);
      @(posedge pclk);
      can_transmit_pin <= 1'b1;
      can_bus_rx <= 1'b0;
      tick(3);
      check(can_receive_pin, 1'b1);
      cmd(16'hc080);
      check(can_receive_pin, 1'b0);
      cmd(16'hc000);
   endtask

   task automatic t_lock(input bit lin);
      repeat (2)
      begin
         @(posedge pclk);
         fail[lin] <= 1'b1;
         @(posedge pclk);
         fail[lin] <= 1'b0;
         tick(2);
         check(txen[lin], 1'b0);
         rdr(ADDR_STATUS);
         check({rd[13 - lin], rd[11:0]}, 13'h1000);
      end
      cmd(lin ? 16'hc001 : 16'hc100);
      cmd(16'hc000);
      check(txen[lin], 1'b1);
      @(posedge pclk);
      fail[lin] <= 1'b1;
      @(posedge pclk);
      fail[lin] <= 1'b0;
      good[lin] <= 1'b1;
      @(posedge pclk);
      good[lin] <= 1'b0;
      tick(2);
      check(txen[lin], 1'b1);
   endtask

   task automatic t_wake;
      for (int b = 0; b < 2; b++)
      begin
         cmd({4'hc, 10'h000, b[0], 1'b0});
         @(posedge pclk);
         lin_bus_wake <= 1'b1;
         @(posedge pclk);
         lin_bus_wake <= 1'b0;
         #1;
         check(lin_wake_event, b[0]);
      end
   endtask

   task automatic t_timeout(input logic [15:0] w, input bit wk, input int n);
      cmd(w);
      @(posedge pclk);
      wake_event <= wk;
      @(posedge pclk);
      wake_event <= 1'b0;
      can_bus_activity <= 1'b1;
      tick(4);
      check(can_offline, 1'b0);
      @(posedge pclk);
      can_bus_activity <= 1'b0;
      tick(n - 8);
      check(can_offline, 1'b0);
      tick(16);
      check(can_offline, 1'b1);
   endtask

   task automatic t_listen_active;
      @(posedge pclk);
      chip_normal_or_flash <= 1'b0;
      cmd(16'hc400);
      @(posedge pclk);
      can_bus_activity <= 1'b1;
      tick(4);
      check({can_online_listen, can_offline, can_active}, 3'b100);
      cmd(16'hc450);
      check({can_active, lin_active}, 2'b00);
      @(posedge pclk);
      chip_normal_or_flash <= 1'b1;
      tick(6);
      check({can_active, lin_active}, 2'b11);
      rdr(ADDR_STATUS);
      check({rd[15:14], rd[11:0]}, 14'h3050);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      tick(2);
      t_reset();
      t_fields();
      t_select();
      t_loop();
      t_lock(1'b0);
      t_lock(1'b1);
      t_wake();
      t_timeout(16'hc000, 1'b0, OFF_SHORT_CYC);
      t_timeout(16'hc200, 1'b0, OFF_LONG_CYC);
      t_timeout(16'hc000, 1'b1, OFF_EXT_CYC);
      t_listen_active();
      tally_and_finish();
   end

   initial
   begin
      #(20000 * 50);
      bad_count++;
      tally_and_finish();
   end
endmodule
